// file: addr_gen_pkg.sv
// Purpose: shared types and constants for the operand address generator
// Assumes: 16-bit address bus, 8-bit data, opcode already decoded upstream
// Notes:   group and mode codes are set by the decoder, not by opcode bits
package addr_gen_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;

   // highest address an 8-bit offset indexed access can reach
   localparam logic [15:0] IX1_TOP = 16'h01fe;
   localparam logic [7:0] PAGE_ZERO = 8'h00;
   localparam logic [15:0] ADDR_ZERO = 16'h0000;

   localparam logic [1:0] OPERANDS_NONE = 2'h0;
   localparam logic [1:0] OPERANDS_ONE = 2'h1;
   localparam logic [1:0] OPERANDS_TWO = 2'h2;
   localparam logic [15:0] STEP_ONE = 16'h0001;
   localparam logic [15:0] STEP_TWO = 16'h0002;

   typedef enum logic [2:0] {
      mode_inherent = 3'h0,
      mode_immediate = 3'h1,
      mode_direct = 3'h2,
      mode_extended = 3'h3,
      mode_ix0 = 3'h4,
      mode_ix1 = 3'h5,
      mode_ix2 = 3'h6,
      mode_relative = 3'h7
   } addr_mode_t;

   typedef enum logic [2:0] {
      grp_rmw = 3'h0,
      grp_regmem = 3'h1,
      grp_jump = 3'h2,
      grp_branch = 3'h3,
      grp_bit_branch = 3'h4,
      grp_mul = 3'h5,
      grp_control = 3'h6
   } op_group_t;

   typedef enum logic [1:0] {
      st_idle = 2'h0,
      st_byte1 = 2'h1,
      st_byte2 = 2'h2,
      st_calc = 2'h3
   } gen_state_t;

endpackage

// file: operand_addr_gen.sv
// Purpose: effective address, branch target and multiply placement
// Assumes: one request at a time; operand bytes come from program memory
// Notes:   opcode byte itself is fetched elsewhere; pc_in is its address
`timescale 1ns/1ps

// Contract
// RL1: no-offset indexed address is index register low byte, high byte zero.
// RL2: no-offset indexed instructions are one byte, no operand fetch.
// RL3: 8-bit offset address is unsigned index plus unsigned offset, up to 510.
// RL4: 8-bit offset indexed instructions are two bytes.
// RL5: 16-bit offset address is 8-bit index plus 16-bit unsigned offset.
// RL6: first offset byte fetched is high byte, second is low byte.
// RL7: 16-bit offset indexed instructions are three bytes.
// RL8: relative addressing only for the branch groups.
// RL9: taken branch loads pc with next pc plus sign-extended offset.
// RL10: untaken branch moves pc to the following instruction.
// RL11: offset is two's complement, measured from the next instruction address.
// RL12: multiply puts product high byte in index, low byte in accumulator.
// RL13: read-modify-write group accepts no-offset and 8-bit offset indexed only.
// RL14: register/memory and jump groups accept all three indexed forms.
// RL15: register/memory uses immediate, direct, extended or indexed operand forms.
// RL16: direct address is next byte with high byte forced to zero.
// RL17: extended address is next two bytes, high first; three-byte instruction.
// RL18: address sums wrap at 16 bits, carry discarded.
module operand_addr_gen (
   input wire logic mclk, // 25 MHz core clock
   input wire logic rst, // async reset, active high
   input wire logic start, // request pulse, taken when idle
   input wire addr_gen_pkg::op_group_t grp_in, // decoded group
   input wire addr_gen_pkg::addr_mode_t mode_in, // decoded addressing form
   input wire logic cond_in, // branch condition result
   input wire logic [15:0] pc_in, // address of the opcode
   input wire logic [7:0] acc_in, // accumulator value
   input wire logic [7:0] idx_in, // index register value
   input wire logic rd_valid, // operand byte present
   input wire logic [7:0] rd_data, // operand byte
   output logic busy_reg, // request in progress
   output logic fetch_req_reg, // operand byte wanted
   output logic [15:0] fetch_addr_reg, // operand byte address
   output logic done_reg, // results valid, one cycle
   output logic illegal_reg, // form refused, one cycle
   output logic [15:0] ea_reg, // effective operand address
   output logic [15:0] pc_next_reg, // new program counter
   output logic [1:0] len_reg, // instruction length in bytes
   output logic mul_wr_reg, // multiply results valid, one cycle
   output logic [7:0] acc_res_reg, // product low byte
   output logic [7:0] idx_res_reg // product high byte
);

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic logic form_legal(addr_gen_pkg::op_group_t g,
                                       addr_gen_pkg::addr_mode_t m);
      logic ok;
      ok = 1'b0;
      case (g)
         addr_gen_pkg::grp_rmw: begin
            ok = m inside {addr_gen_pkg::mode_inherent, addr_gen_pkg::mode_direct,
                           addr_gen_pkg::mode_ix0, addr_gen_pkg::mode_ix1}; // RL13
         end
         addr_gen_pkg::grp_regmem: begin
            ok = m != addr_gen_pkg::mode_inherent && m != addr_gen_pkg::mode_relative; // RL15
         end
         addr_gen_pkg::grp_jump: begin
            ok = m inside {addr_gen_pkg::mode_direct, addr_gen_pkg::mode_extended,
                           addr_gen_pkg::mode_ix0, addr_gen_pkg::mode_ix1,
                           addr_gen_pkg::mode_ix2}; // RL14
         end
         addr_gen_pkg::grp_branch, addr_gen_pkg::grp_bit_branch: begin
            ok = m == addr_gen_pkg::mode_relative; // RL8
         end
         default: begin
            ok = m == addr_gen_pkg::mode_inherent;
         end
      endcase
      return ok;
   endfunction

   // bytes following the opcode
   function automatic logic [1:0] operand_bytes(addr_gen_pkg::op_group_t g,
                                                addr_gen_pkg::addr_mode_t m);
      logic [1:0] n;
      n = addr_gen_pkg::OPERANDS_NONE;
      if (g == addr_gen_pkg::grp_bit_branch) begin
         n = addr_gen_pkg::OPERANDS_TWO;
      end else if (m == addr_gen_pkg::mode_extended || m == addr_gen_pkg::mode_ix2) begin
         n = addr_gen_pkg::OPERANDS_TWO; // RL7 RL17
      end else if (m == addr_gen_pkg::mode_inherent || m == addr_gen_pkg::mode_ix0) begin
         n = addr_gen_pkg::OPERANDS_NONE; // RL2
      end else begin
         n = addr_gen_pkg::OPERANDS_ONE; // RL4
      end
      return n;
   endfunction

   // ------------------------------------------------------------
   // request capture
   // ------------------------------------------------------------
   addr_gen_pkg::gen_state_t state_reg;
   addr_gen_pkg::op_group_t grp_reg;
   addr_gen_pkg::addr_mode_t mode_reg;
   logic cond_reg;
   logic [15:0] pc_reg;
   logic [7:0] acc_reg;
   logic [7:0] idx_reg;
   logic [1:0] nbytes_reg;
   logic [7:0] b1_reg;
   logic [7:0] b2_reg;
   logic accept;

   assign accept = start && state_reg == addr_gen_pkg::st_idle;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         grp_reg <= addr_gen_pkg::grp_control;
         mode_reg <= addr_gen_pkg::mode_inherent;
         cond_reg <= 1'b0;
         pc_reg <= addr_gen_pkg::ADDR_ZERO;
         acc_reg <= addr_gen_pkg::PAGE_ZERO;
         idx_reg <= addr_gen_pkg::PAGE_ZERO;
         nbytes_reg <= addr_gen_pkg::OPERANDS_NONE;
      end else if (accept) begin
         grp_reg <= grp_in;
         mode_reg <= mode_in;
         cond_reg <= cond_in;
         pc_reg <= pc_in;
         acc_reg <= acc_in;
         idx_reg <= idx_in;
         nbytes_reg <= operand_bytes(grp_in, mode_in);
      end
   end

   // ------------------------------------------------------------
   // sequencer and operand fetch
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg <= addr_gen_pkg::st_idle;
         fetch_req_reg <= 1'b0;
         fetch_addr_reg <= addr_gen_pkg::ADDR_ZERO;
         b1_reg <= addr_gen_pkg::PAGE_ZERO;
         b2_reg <= addr_gen_pkg::PAGE_ZERO;
         illegal_reg <= 1'b0;
      end else begin
         illegal_reg <= 1'b0;
         case (state_reg)
            addr_gen_pkg::st_idle: begin
               if (start && !form_legal(grp_in, mode_in)) begin
                  illegal_reg <= 1'b1;
               end else if (start) begin
                  if (operand_bytes(grp_in, mode_in) == addr_gen_pkg::OPERANDS_NONE) begin
                     state_reg <= addr_gen_pkg::st_calc; // RL2
                  end else begin
                     state_reg <= addr_gen_pkg::st_byte1;
                     fetch_req_reg <= 1'b1;
                     fetch_addr_reg <= pc_in + addr_gen_pkg::STEP_ONE;
                  end
               end
            end
            addr_gen_pkg::st_byte1: begin
               if (rd_valid) begin
                  b1_reg <= rd_data;
                  if (nbytes_reg == addr_gen_pkg::OPERANDS_TWO) begin
                     state_reg <= addr_gen_pkg::st_byte2;
                     fetch_addr_reg <= pc_reg + addr_gen_pkg::STEP_TWO;
                  end else begin
                     state_reg <= addr_gen_pkg::st_calc;
                     fetch_req_reg <= 1'b0;
                  end
               end
            end
            addr_gen_pkg::st_byte2: begin
               if (rd_valid) begin
                  b2_reg <= rd_data;
                  state_reg <= addr_gen_pkg::st_calc;
                  fetch_req_reg <= 1'b0;
               end
            end
            default: begin
               state_reg <= addr_gen_pkg::st_idle;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // address arithmetic
   // ------------------------------------------------------------
   logic [15:0] ea_calc;
   logic [15:0] seq_pc;
   logic [15:0] target;
   logic [7:0] rel_off;
   logic [15:0] product;

   always_comb begin
      ea_calc = addr_gen_pkg::ADDR_ZERO;
      case (mode_reg)
         addr_gen_pkg::mode_direct: ea_calc = {addr_gen_pkg::PAGE_ZERO, b1_reg}; // RL16
         addr_gen_pkg::mode_extended: ea_calc = {b1_reg, b2_reg}; // RL17
         addr_gen_pkg::mode_ix0: ea_calc = {addr_gen_pkg::PAGE_ZERO, idx_reg}; // RL1
         addr_gen_pkg::mode_ix1: begin
            ea_calc = {addr_gen_pkg::PAGE_ZERO, idx_reg} +
                      {addr_gen_pkg::PAGE_ZERO, b1_reg}; // RL3
         end
         addr_gen_pkg::mode_ix2: begin
            ea_calc = 16'({b1_reg, b2_reg} + {addr_gen_pkg::PAGE_ZERO, idx_reg}); // RL5 RL6 RL18
         end
         default: ea_calc = addr_gen_pkg::ADDR_ZERO;
      endcase
      // bit-test branch carries its tested byte address first
      if (grp_reg == addr_gen_pkg::grp_bit_branch) begin
         ea_calc = {addr_gen_pkg::PAGE_ZERO, b1_reg};
      end
   end

   assign seq_pc = 16'(pc_reg + addr_gen_pkg::STEP_ONE + {14'h0000, nbytes_reg}); // RL18
   assign rel_off = grp_reg == addr_gen_pkg::grp_bit_branch ? b2_reg : b1_reg;
   // measured from the following instruction, sign extended
   assign target = 16'(seq_pc + {{8{rel_off[7]}}, rel_off}); // RL11 RL18
   assign product = acc_reg * idx_reg;

   // ------------------------------------------------------------
   // results
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         done_reg <= 1'b0;
         ea_reg <= addr_gen_pkg::ADDR_ZERO;
         pc_next_reg <= addr_gen_pkg::ADDR_ZERO;
         len_reg <= addr_gen_pkg::OPERANDS_NONE;
      end else begin
         done_reg <= state_reg == addr_gen_pkg::st_calc;
         if (state_reg == addr_gen_pkg::st_calc) begin
            ea_reg <= ea_calc;
            len_reg <= nbytes_reg + addr_gen_pkg::OPERANDS_ONE;
            if (grp_reg == addr_gen_pkg::grp_jump) begin
               pc_next_reg <= ea_calc;
            end else if ((grp_reg == addr_gen_pkg::grp_branch ||
                          grp_reg == addr_gen_pkg::grp_bit_branch) && cond_reg) begin
               pc_next_reg <= target; // RL9
            end else begin
               pc_next_reg <= seq_pc; // RL10
            end
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mul_wr_reg <= 1'b0;
         acc_res_reg <= addr_gen_pkg::PAGE_ZERO;
         idx_res_reg <= addr_gen_pkg::PAGE_ZERO;
      end else begin
         mul_wr_reg <= state_reg == addr_gen_pkg::st_calc && grp_reg == addr_gen_pkg::grp_mul;
         if (state_reg == addr_gen_pkg::st_calc && grp_reg == addr_gen_pkg::grp_mul) begin
            idx_res_reg <= product[15:8]; // RL12
            acc_res_reg <= product[7:0]; // RL12
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= accept ? form_legal(grp_in, mode_in) :
                     state_reg != addr_gen_pkg::st_calc && state_reg != addr_gen_pkg::st_idle;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   no_offset_addr_a: assert property ((accept && mode_in == addr_gen_pkg::mode_ix0 &&
      form_legal(grp_in, mode_in)) |-> ##2 done_reg &&
      ea_reg == {addr_gen_pkg::PAGE_ZERO, $past(idx_in, 2)}) // RL1
      else $error("no-offset address wrong");
   no_offset_len_a: assert property ((accept && mode_in == addr_gen_pkg::mode_ix0) |=>
      !fetch_req_reg [*2]) // RL2
      else $error("no-offset fetched an operand");
   short_ix_range_a: assert property ((done_reg && mode_reg == addr_gen_pkg::mode_ix1) |->
      ea_reg <= addr_gen_pkg::IX1_TOP && len_reg == addr_gen_pkg::OPERANDS_TWO) // RL3 RL4
      else $error("8-bit offset address or length wrong");
   long_ix_sum_a: assert property ((done_reg && mode_reg == addr_gen_pkg::mode_ix2) |->
      16'(ea_reg - {addr_gen_pkg::PAGE_ZERO, idx_reg}) == {b1_reg, b2_reg}) // RL5 RL6
      else $error("16-bit offset address wrong");
   long_ix_len_a: assert property ((done_reg && mode_reg == addr_gen_pkg::mode_ix2) |->
      len_reg == 2'h3) // RL7
      else $error("16-bit offset length wrong");
   branch_taken_a: assert property ((done_reg && grp_reg == addr_gen_pkg::grp_branch &&
      cond_reg) |-> pc_next_reg == 16'(pc_reg + 16'h0002 + {{8{b1_reg[7]}}, b1_reg})) // RL9 RL11
      else $error("taken branch target wrong");
   branch_not_taken_a: assert property ((done_reg && grp_reg == addr_gen_pkg::grp_branch &&
      !cond_reg) |-> pc_next_reg == 16'(pc_reg + 16'h0002)) // RL10
      else $error("untaken branch pc wrong");
   mul_place_a: assert property (mul_wr_reg |->
      {idx_res_reg, acc_res_reg} == 16'(acc_reg * idx_reg)) // RL12
      else $error("multiply result misplaced");
   rmw_refuse_a: assert property ((accept && grp_in == addr_gen_pkg::grp_rmw &&
      mode_in == addr_gen_pkg::mode_ix2) |=> illegal_reg && !busy_reg) // RL13
      else $error("read-modify-write 16-bit offset accepted");
   relative_only_a: assert property ((accept && mode_in == addr_gen_pkg::mode_relative &&
      grp_in == addr_gen_pkg::grp_regmem) |=> illegal_reg) // RL8
      else $error("relative form accepted outside branches");

   ix2_seen_c: cover property (done_reg && mode_reg == addr_gen_pkg::mode_ix2);
   taken_back_c: cover property (done_reg && cond_reg && grp_reg == addr_gen_pkg::grp_branch &&
      b1_reg[7]);
   bitbr_c: cover property (done_reg && grp_reg == addr_gen_pkg::grp_bit_branch);
   mul_c: cover property (mul_wr_reg);

endmodule

// file: op_mem_model.sv
// Purpose: program memory seen by the operand fetch port
// Assumes: one byte answered per address presented, after lat idle cycles
// Notes:   first byte of a request is b1, the next is b2
`timescale 1ns/1ps

module op_mem_model (
   input wire logic mclk, // core clock
   input wire logic rst, // async reset, active high
   input wire logic fetch_req, // byte wanted
   input wire logic [15:0] fetch_addr, // byte address
   input wire logic [1:0] lat, // idle cycles before answering
   input wire logic [7:0] b1, // first operand byte
   input wire logic [7:0] b2, // second operand byte
   output logic rd_valid, // byte present, one cycle
   output logic [7:0] rd_data // byte value
);
   logic [1:0] wait_reg;
   logic served_reg;
   logic [15:0] served_addr_reg;
   logic fresh;

   // an address already answered gets no second valid
   assign fresh = fetch_req && !(served_reg && fetch_addr == served_addr_reg);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_valid <= 1'b0;
         rd_data <= 8'h00;
         wait_reg <= 2'h0;
         served_reg <= 1'b0;
         served_addr_reg <= 16'h0000;
      end else if (fresh && wait_reg == lat) begin
         rd_valid <= 1'b1;
         rd_data <= served_reg ? b2 : b1;
         served_reg <= 1'b1;
         served_addr_reg <= fetch_addr;
         wait_reg <= 2'h0;
      end else begin
         // data line keeps changing so a stale byte is never mistaken for a fresh one
         rd_valid <= 1'b0;
         rd_data <= ~rd_data;
         if (fresh)
            wait_reg <= wait_reg + 2'h1;
         if (!fetch_req)
            served_reg <= 1'b0;
      end
   end
endmodule

// file: tb_operand_addr_gen.sv
// Purpose: self-checking bench for the operand address generator
// Assumes: inputs change at the falling edge, 40 ns clock
// Notes:   acc_in is driven by send as the inverse of idx_in; both start at zero
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fails++; \
   $display("[FAIL] %s exp %h got %h", nm, ex, got); end end

module tb_operand_addr_gen;
   typedef struct {
      addr_gen_pkg::op_group_t grp;
      addr_gen_pkg::addr_mode_t mode;
      logic cond;
      logic [15:0] pc;
      logic [7:0] idx;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [1:0] lat;
      logic ill;
      logic [15:0] ea;
      logic [15:0] pcn;
      logic [1:0] len;
   } row_t;

   logic mclk = 1'b0;
   logic rst, start, cond_in, rd_valid;
   addr_gen_pkg::op_group_t grp_in;
   addr_gen_pkg::addr_mode_t mode_in;
   logic [15:0] pc_in, fetch_addr_reg, ea_reg, pc_next_reg;
   logic [7:0] acc_in, idx_in, rd_data, b1, b2, acc_res_reg, idx_res_reg, h_acc, h_idx;
   logic [1:0] lat, len_reg;
   logic busy_reg, fetch_req_reg, done_reg, illegal_reg, mul_wr_reg, extra;
   int fails = 0;
   int tests_run = 0;
   int cycles = 0;
   row_t rows [18];
   row_t rb;

   always #20 mclk = ~mclk;

   operand_addr_gen i_operand_addr_gen (.mclk(mclk), .rst(rst), .start(start), .grp_in(grp_in),
      .mode_in(mode_in), .cond_in(cond_in), .pc_in(pc_in), .acc_in(acc_in), .idx_in(idx_in),
      .rd_valid(rd_valid), .rd_data(rd_data), .busy_reg(busy_reg),
      .fetch_req_reg(fetch_req_reg), .fetch_addr_reg(fetch_addr_reg), .done_reg(done_reg),
      .illegal_reg(illegal_reg), .ea_reg(ea_reg), .pc_next_reg(pc_next_reg), .len_reg(len_reg),
      .mul_wr_reg(mul_wr_reg), .acc_res_reg(acc_res_reg), .idx_res_reg(idx_res_reg));

   op_mem_model i_op_mem_model (.mclk(mclk), .rst(rst), .fetch_req(fetch_req_reg),
      .fetch_addr(fetch_addr_reg), .lat(lat), .b1(b1), .b2(b2), .rd_valid(rd_valid),
      .rd_data(rd_data));

   task report_and_stop;
      if (fails == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // a hang in any wait ends here as a counted mismatch
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         report_and_stop();
      end
   end

   task send(input row_t r);
      @(negedge mclk);
      grp_in = r.grp;
      mode_in = r.mode;
      cond_in = r.cond;
      pc_in = r.pc;
      idx_in = r.idx;
      acc_in = ~r.idx;
      b1 = r.b1;
      b2 = r.b2;
      lat = r.lat;
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
   endtask

   // the refusal pulse already stands when send returns, so look before the first wait
   task wait_end;
      for (int k = 0; k < 40; k++) begin
         if (done_reg === 1'b1 || illegal_reg === 1'b1)
            break;
         @(posedge mclk);
         #1;
      end
   endtask

   task check(input row_t r);
      `CHK("illegal", r.ill, illegal_reg)
      `CHK("done", ~r.ill, done_reg)
      if (!r.ill) begin
         `CHK("ea", r.ea, ea_reg)
         `CHK("pc_next", r.pcn, pc_next_reg)
         `CHK("len", r.len, len_reg)
         `CHK("mul_wr", r.grp == addr_gen_pkg::grp_mul, mul_wr_reg)
         `CHK("acc_res", h_acc, acc_res_reg)
         `CHK("idx_res", h_idx, idx_res_reg)
      end
   endtask

   task run(input row_t r);
      send(r);
      wait_end();
      if (r.grp == addr_gen_pkg::grp_mul)
         {h_idx, h_acc} = acc_in * idx_in;
      check(r);
      if (r.ill)
         @(posedge mclk);
   endtask

   initial begin
      {rst, start, cond_in, pc_in, acc_in, idx_in, b1, b2, lat, h_acc, h_idx} = '0;
      grp_in = addr_gen_pkg::grp_control;
      mode_in = addr_gen_pkg::mode_inherent;
      rst = 1'b1;
      // -----------------------------------------------------------------
      // rows: group, form, cond, pc, idx, bytes, latency, expected
      // -----------------------------------------------------------------
      rows[0] = '{addr_gen_pkg::grp_rmw, addr_gen_pkg::mode_ix0, 1'b0, 16'h1000, 8'hff,
         8'h00, 8'h00, 2'h0, 1'b0, 16'h00ff, 16'h1001, 2'h1};
      rows[1] = '{addr_gen_pkg::grp_rmw, addr_gen_pkg::mode_ix1, 1'b0, 16'h1000, 8'hff,
         8'hff, 8'h00, 2'h1, 1'b0, 16'h01fe, 16'h1002, 2'h2};
      rows[2] = '{addr_gen_pkg::grp_rmw, addr_gen_pkg::mode_ix2, 1'b0, 16'h1000, 8'h01,
         8'h00, 8'h00, 2'h0, 1'b1, 16'h0000, 16'h0000, 2'h0};
      rows[3] = '{addr_gen_pkg::grp_regmem, addr_gen_pkg::mode_ix2, 1'b0, 16'h2000, 8'h80,
         8'h12, 8'h34, 2'h0, 1'b0, 16'h12b4, 16'h2003, 2'h3};
      rows[4] = '{addr_gen_pkg::grp_regmem, addr_gen_pkg::mode_ix2, 1'b0, 16'h2000, 8'h02,
         8'hff, 8'hff, 2'h2, 1'b0, 16'h0001, 16'h2003, 2'h3};
      rows[5] = '{addr_gen_pkg::grp_regmem, addr_gen_pkg::mode_direct, 1'b0, 16'h2000, 8'h00,
         8'h80, 8'h00, 2'h0, 1'b0, 16'h0080, 16'h2002, 2'h2};
      rows[6] = '{addr_gen_pkg::grp_regmem, addr_gen_pkg::mode_extended, 1'b0, 16'h2000, 8'h00,
         8'hab, 8'hcd, 2'h1, 1'b0, 16'habcd, 16'h2003, 2'h3};
      rows[7] = '{addr_gen_pkg::grp_regmem, addr_gen_pkg::mode_immediate, 1'b0, 16'h2000, 8'h00,
         8'h55, 8'h00, 2'h0, 1'b0, 16'h0000, 16'h2002, 2'h2};
      rows[8] = '{addr_gen_pkg::grp_regmem, addr_gen_pkg::mode_inherent, 1'b0, 16'h2000, 8'h00,
         8'h00, 8'h00, 2'h0, 1'b1, 16'h0000, 16'h0000, 2'h0};
      rows[9] = '{addr_gen_pkg::grp_jump, addr_gen_pkg::mode_ix2, 1'b0, 16'h2000, 8'h10,
         8'h40, 8'h00, 2'h0, 1'b0, 16'h4010, 16'h4010, 2'h3};
      rows[10] = '{addr_gen_pkg::grp_jump, addr_gen_pkg::mode_ix0, 1'b0, 16'h2000, 8'h33,
         8'h00, 8'h00, 2'h0, 1'b0, 16'h0033, 16'h0033, 2'h1};
      rows[11] = '{addr_gen_pkg::grp_branch, addr_gen_pkg::mode_relative, 1'b1, 16'h3000, 8'h00,
         8'h80, 8'h00, 2'h0, 1'b0, 16'h0000, 16'h2f82, 2'h2};
      rows[12] = '{addr_gen_pkg::grp_branch, addr_gen_pkg::mode_relative, 1'b1, 16'hfff0, 8'h00,
         8'h7f, 8'h00, 2'h1, 1'b0, 16'h0000, 16'h0071, 2'h2};
      rows[13] = '{addr_gen_pkg::grp_branch, addr_gen_pkg::mode_relative, 1'b0, 16'h3000, 8'h00,
         8'h10, 8'h00, 2'h0, 1'b0, 16'h0000, 16'h3002, 2'h2};
      rows[14] = '{addr_gen_pkg::grp_branch, addr_gen_pkg::mode_ix1, 1'b1, 16'h3000, 8'h00,
         8'h10, 8'h00, 2'h0, 1'b1, 16'h0000, 16'h0000, 2'h0};
      rows[15] = '{addr_gen_pkg::grp_bit_branch, addr_gen_pkg::mode_relative, 1'b1, 16'h0100,
         8'h00, 8'h44, 8'hfe, 2'h1, 1'b0, 16'h0044, 16'h0101, 2'h3};
      rows[16] = '{addr_gen_pkg::grp_mul, addr_gen_pkg::mode_inherent, 1'b0, 16'h1000, 8'h0f,
         8'h00, 8'h00, 2'h0, 1'b0, 16'h0000, 16'h1001, 2'h1};
      rows[17] = '{addr_gen_pkg::grp_regmem, addr_gen_pkg::mode_relative, 1'b0, 16'h2000, 8'h00,
         8'h10, 8'h00, 2'h0, 1'b1, 16'h0000, 16'h0000, 2'h0};
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      foreach (rows[i])
         run(rows[i]);
      // a start while busy must not disturb the request in flight
      rb = rows[6];
      rb.pc = 16'h6000;
      send(rows[6]);
      send(rb);
      `CHK("busy", 1'b1, busy_reg)
      `CHK("fetch req", 1'b1, fetch_req_reg)
      `CHK("fetch addr 1", 16'h2001, fetch_addr_reg)
      @(negedge mclk);
      `CHK("fetch addr 2", 16'h2002, fetch_addr_reg)
      wait_end();
      check(rows[6]);
      extra = 1'b0;
      for (int k = 0; k < 6; k++) begin
         @(posedge mclk);
         #1;
         extra = extra | done_reg;
      end
      `CHK("second done", 1'b0, extra)
      // reset in mid-fetch clears everything, held products too
      send(rows[4]);
      @(negedge mclk);
      rst = 1'b1;
      #1;
      `CHK("busy rst", 1'b0, busy_reg)
      `CHK("fetch rst", 1'b0, fetch_req_reg)
      `CHK("ea rst", 16'h0000, ea_reg)
      `CHK("idx_res rst", 8'h00, idx_res_reg)
      @(negedge mclk);
      rst = 1'b0;
      h_acc = 8'h00;
      h_idx = 8'h00;
      run(rows[3]);
      report_and_stop();
   end
endmodule
